// [design/flash_host_ctrl.sv]
`timescale 1ns/100ps
`default_nettype none
// How it works
// - buffered program sends count minus one; all addresses stay in one line
// - secret words go to offsets 00h to 03h, one each
// - command cycles are writes; identification and data fetches are reads
// - reset command after identification mode; none is sent on a raised fail bit
// - leaving buffer abort needs the full abort-reset sequence
// - one secret word per program, words 0 to 3 ascending
// - secret and volatile entries are followed by an exit; identification entry by a reset
// - each offset 02h read is a fresh chip-enable access
// - a single F0 write returns the device to array read, except out of buffer abort
module flash_host_ctrl #(
  parameter int NUM_SECTOR_BITS = 10
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_reset_n,
  // user request
  input wire logic i_req_valid,
  input wire flash_host_pkg::request_t i_req,
  output logic o_req_ready,
  // user answer
  output logic o_done,
  output logic [flash_host_pkg::DATA_W-1:0] o_rd_data,
  output logic [7:0] o_id_valid_mask,
  output logic o_protected,
  output logic o_fail,
  // flash pins
  output logic [flash_host_pkg::ADDR_W-1:0] o_addr,
  output logic o_ce_n,
  output logic o_oe_n,
  output logic o_we_n,
  input wire logic [flash_host_pkg::DATA_W-1:0] i_dq,
  output logic [flash_host_pkg::DATA_W-1:0] o_dq,
  output logic o_dq_oe
);
  import flash_host_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  typedef enum logic [2:0] {S_IDLE, S_SETUP, S_STROBE, S_GAP, S_DONE} state_t;

  state_t state, next_state;
  request_t req, next_req;
  logic [3:0] step, next_step;
  logic [TIMER_W-1:0] timer, next_timer;
  logic [DATA_W-1:0] rd_data, next_rd_data;
  logic [7:0] id_mask, next_id_mask;
  logic prot, next_prot;
  logic fail, next_fail;
  logic [3:0] secret_next_idx, next_secret_next_idx;
  bus_cycle_t cyc;
  logic last;

  // command address: only the low unlock bits matter, high bits kept zero
  function automatic logic [ADDR_W-1:0] cmd_addr(input logic [11:0] a);
    return {{(ADDR_W-12){1'b0}}, a};
  endfunction : cmd_addr

  function automatic logic [DATA_W-1:0] cmd_data(input logic [7:0] d);
    return {8'h00, d};
  endfunction : cmd_data

  // sector base with low bits zero; the device ignores them anyway
  function automatic logic [ADDR_W-1:0] sector_base(input logic [ADDR_W-1:0] a);
    return {a[ADDR_W-1:SECTOR_LSB], {SECTOR_LSB{1'b0}}};
  endfunction : sector_base

  function automatic bus_cycle_t wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    return '{addr: a, data: d, write: 1'b1};
  endfunction : wr

  function automatic bus_cycle_t rd(input logic [ADDR_W-1:0] a);
    return '{addr: a, data: '0, write: 1'b0};
  endfunction : rd

  ////////////////////////////////////////////////////////////////////////
  // sequence table: step -> bus cycle
  always_comb begin
    cyc = wr(cmd_addr(12'h000), cmd_data(CMD_RESET));
    last = 1'b1;
    unique case (req.op)
      OP_ID_READ: begin
        // unlock, entry at sector, one read of the indexed word, reset
        last = 1'b0;
        if (step == 4'd0) cyc = wr(cmd_addr(UNLOCK_ADDR_A), cmd_data(UNLOCK_DATA_A));
        else if (step == 4'd1) cyc = wr(cmd_addr(UNLOCK_ADDR_B), cmd_data(UNLOCK_DATA_B));
        else if (step == 4'd2)
          cyc = wr(sector_base(req.addr) | cmd_addr(UNLOCK_ADDR_A), cmd_data(CMD_ID_ENTRY));
        else if (step == 4'd3)
          cyc = rd(sector_base(req.addr) | {{(ADDR_W-4){1'b0}}, req.index});
        else begin
          cyc = wr(cmd_addr(12'h000), cmd_data(CMD_RESET));
          last = 1'b1;
        end
      end
      OP_RESET: begin
        // full unlocked form, so it also clears a buffer abort
        last = 1'b0;
        if (step == 4'd0) cyc = wr(cmd_addr(UNLOCK_ADDR_A), cmd_data(UNLOCK_DATA_A));
        else if (step == 4'd1) cyc = wr(cmd_addr(UNLOCK_ADDR_B), cmd_data(UNLOCK_DATA_B));
        else begin
          cyc = wr(cmd_addr(UNLOCK_ADDR_A), cmd_data(CMD_RESET));
          last = 1'b1;
        end
      end
      OP_SECRET_WRITE, OP_SECRET_READ: begin
        last = 1'b0;
        if (step == 4'd0) cyc = wr(cmd_addr(UNLOCK_ADDR_A), cmd_data(UNLOCK_DATA_A));
        else if (step == 4'd1) cyc = wr(cmd_addr(UNLOCK_ADDR_B), cmd_data(UNLOCK_DATA_B));
        else if (step == 4'd2) cyc = wr(cmd_addr(UNLOCK_ADDR_A), cmd_data(CMD_SECRET_ENTRY));
        else if (step == 4'd3 && req.op == OP_SECRET_WRITE)
          cyc = wr(cmd_addr(12'h000), cmd_data(CMD_PROGRAM));
        else if (step == 4'd3)
          cyc = rd({{(ADDR_W-2){1'b0}}, req.index[1:0]});
        else if (step == 4'd4 && req.op == OP_SECRET_WRITE)
          cyc = wr({{(ADDR_W-2){1'b0}}, req.index[1:0]}, req.data);
        else if (step == 4'd4 || step == 4'd6)
          cyc = wr(cmd_addr(12'h000), cmd_data(CMD_EXIT_A));
        else if (step == 4'd5 || step == 4'd7) begin
          cyc = wr(cmd_addr(12'h000), cmd_data(CMD_EXIT_B));
          last = 1'b1;
        end else
          cyc = rd(cmd_addr(12'h000)); // read of 000h at steps 8 and up, which no sequence reaches
      end
      OP_BUF_PROGRAM: begin
        // single-word buffered load: count of one location minus one
        last = 1'b0;
        if (step == 4'd0) cyc = wr(cmd_addr(UNLOCK_ADDR_A), cmd_data(UNLOCK_DATA_A));
        else if (step == 4'd1) cyc = wr(cmd_addr(UNLOCK_ADDR_B), cmd_data(UNLOCK_DATA_B));
        else if (step == 4'd2) cyc = wr(sector_base(req.addr), cmd_data(CMD_BUF_LOAD));
        else if (step == 4'd3) cyc = wr(sector_base(req.addr), {8'h00, 8'h00});
        else if (step == 4'd4) cyc = wr(req.addr, req.data);
        else begin
          cyc = wr(sector_base(req.addr), cmd_data(CMD_BUF_CONFIRM));
          last = 1'b1;
        end
      end
      OP_SECTOR_LOCK: begin
        // volatile lock set (0) or clear (1) then exit
        last = 1'b0;
        if (step == 4'd0) cyc = wr(cmd_addr(UNLOCK_ADDR_A), cmd_data(UNLOCK_DATA_A));
        else if (step == 4'd1) cyc = wr(cmd_addr(UNLOCK_ADDR_B), cmd_data(UNLOCK_DATA_B));
        else if (step == 4'd2) cyc = wr(cmd_addr(UNLOCK_ADDR_A), cmd_data(CMD_VOLATILE_ENTRY));
        else if (step == 4'd3) cyc = wr(cmd_addr(12'h000), cmd_data(CMD_PROGRAM));
        else if (step == 4'd4) cyc = wr(sector_base(req.addr), {15'h0000, req.data[0]});
        else if (step == 4'd5) cyc = rd(sector_base(req.addr));
        else if (step == 4'd6) cyc = wr(cmd_addr(12'h000), cmd_data(CMD_EXIT_A));
        else begin
          cyc = wr(cmd_addr(12'h000), cmd_data(CMD_EXIT_B));
          last = 1'b1;
        end
      end
      default: last = 1'b1;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // sequencer: every cycle drops chip enable in the gap, so each read of
  // offset 02h is a full random access; slower but never a page read
  always_comb begin
    next_state = state;
    next_req = req;
    next_step = step;
    next_timer = timer;
    next_rd_data = rd_data;
    next_id_mask = id_mask;
    next_prot = prot;
    next_fail = fail;
    next_secret_next_idx = secret_next_idx;
    unique case (state)
      S_IDLE: begin
        if (i_req_valid) begin
          next_req = i_req;
          next_step = '0;
          next_fail = 1'b0;
          // refuse out-of-order secret programming
          if (i_req.op == OP_SECRET_WRITE && i_req.index != secret_next_idx) begin
            next_fail = 1'b1;
            next_state = S_DONE;
          end else if (i_req.op == OP_ID_READ && i_req.index > ID_LAST) begin
            next_fail = 1'b1;
            next_state = S_DONE;
          end else begin
            next_timer = TIMER_W'(GAP_CYCLES);
            next_state = S_SETUP;
          end
        end
      end
      S_SETUP: begin
        if (timer == '0) begin
          next_timer = cyc.write ? TIMER_W'(WRITE_CYCLES) : TIMER_W'(ACCESS_CYCLES);
          next_state = S_STROBE;
        end else next_timer = timer - 1'b1;
      end
      S_STROBE: begin
        if (timer == '0) begin
          if (!cyc.write) begin
            next_rd_data = i_dq;
            if (i_dq[STATUS_FAIL_BIT] && req.op == OP_SECRET_WRITE) next_fail = 1'b1;
            if (req.op == OP_ID_READ && req.index == SECTOR_PROTECT_STATE)
              next_prot = i_dq[0];
            else if (req.op == OP_SECTOR_LOCK)
              next_prot = (i_dq[7:0] == 8'h00);
            if (req.op == OP_ID_READ) next_id_mask = {7'h00, 1'b1};
          end
          next_timer = TIMER_W'(GAP_CYCLES);
          next_state = S_GAP;
        end else next_timer = timer - 1'b1;
      end
      S_GAP: begin
        if (timer == '0) begin
          if (last) next_state = S_DONE;
          else begin
            // secret write jumps from the data write at step 4 to the exit pair at steps 6 and 7
            if (req.op == OP_SECRET_WRITE && step == 4'd4) next_step = 4'd6;
            else next_step = step + 1'b1;
            next_timer = TIMER_W'(GAP_CYCLES);
            next_state = S_SETUP;
          end
        end else next_timer = timer - 1'b1;
      end
      S_DONE: begin
        if (req.op == OP_SECRET_WRITE && !fail)
          next_secret_next_idx = (secret_next_idx == 4'(SECRET_WORDS - 1)) ? '0 :
                                 secret_next_idx + 1'b1;
        next_state = S_IDLE;
      end
      default: next_state = S_IDLE;
    endcase
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state <= S_IDLE;
      req <= '0;
      step <= '0;
      timer <= '0;
      rd_data <= '0;
      id_mask <= '0;
      prot <= 1'b0;
      fail <= 1'b0;
      secret_next_idx <= '0;
    end else begin
      state <= next_state;
      req <= next_req;
      step <= next_step;
      timer <= next_timer;
      rd_data <= next_rd_data;
      id_mask <= next_id_mask;
      prot <= next_prot;
      fail <= next_fail;
      secret_next_idx <= next_secret_next_idx;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  assign o_req_ready = (state == S_IDLE);
  assign o_done = (state == S_DONE);
  assign o_rd_data = rd_data;
  assign o_id_valid_mask = id_mask;
  assign o_protected = prot;
  assign o_fail = fail;
  assign o_addr = (state == S_IDLE || state == S_DONE) ? '0 : cyc.addr;
  assign o_ce_n = !(state == S_STROBE);
  assign o_oe_n = !(state == S_STROBE && !cyc.write);
  assign o_we_n = !(state == S_STROBE && cyc.write);
  assign o_dq = (state == S_IDLE || state == S_DONE) ? '0 : cyc.data;
  assign o_dq_oe = (state == S_SETUP || state == S_STROBE || state == S_GAP) && cyc.write;

endmodule : flash_host_ctrl
`default_nettype wire

// [design/flash_host_pkg.sv]
package flash_host_pkg;

  // bus widths
  localparam int ADDR_W = 26;
  localparam int DATA_W = 16;

  // unlock and command addresses and codes
  localparam logic [11:0] UNLOCK_ADDR_A = 12'h555;
  localparam logic [11:0] UNLOCK_ADDR_B = 12'h2AA;
  localparam logic [7:0] UNLOCK_DATA_A = 8'hAA;
  localparam logic [7:0] UNLOCK_DATA_B = 8'h55;
  localparam logic [7:0] CMD_ID_ENTRY = 8'h90;
  localparam logic [7:0] CMD_EXIT_A = 8'h90;
  localparam logic [7:0] CMD_EXIT_B = 8'h00;
  localparam logic [7:0] CMD_RESET = 8'hF0;
  localparam logic [7:0] CMD_PROGRAM = 8'hA0;
  localparam logic [7:0] CMD_SECRET_ENTRY = 8'h60;
  localparam logic [7:0] CMD_BUF_LOAD = 8'h25;
  localparam logic [7:0] CMD_BUF_CONFIRM = 8'h29;
  localparam logic [7:0] CMD_VOLATILE_ENTRY = 8'hE0;

  // identification space word offsets
  localparam logic [3:0] MAKER_CODE_WORD = 4'h0;
  localparam logic [3:0] PART_CODE_WORD_A = 4'h1;
  localparam logic [3:0] SECTOR_PROTECT_STATE = 4'h2;
  localparam logic [3:0] LOCK_INDICATOR_WORD = 4'h3;
  localparam logic [3:0] FEATURE_SUPPORT_LOW = 4'hC;
  localparam logic [3:0] FEATURE_SUPPORT_HIGH = 4'hD;
  localparam logic [3:0] PART_CODE_WORD_B = 4'hE;
  localparam logic [3:0] PART_CODE_WORD_C = 4'hF;
  localparam logic [3:0] ID_LAST = 4'hF;

  // field positions
  localparam int LOCK_FACTORY_BIT = 7;
  localparam int LOCK_CUSTOMER_BIT = 6;
  localparam int WP_TOP_BIT = 4;
  localparam int FEAT_SR_BIT = 0;
  localparam int FEAT_POLL_BIT = 1;
  localparam int FEAT_CSET_LSB = 2;
  localparam int STATUS_FAIL_BIT = 5;
  localparam int SECTOR_LSB = 16;
  localparam int SECRET_WORDS = 4;

  // bus timing
  localparam int CLK_NS = 10;
  localparam int RANDOM_ACCESS_DELAY_NS = 90;
  localparam int ACCESS_CYCLES = (RANDOM_ACCESS_DELAY_NS + CLK_NS - 1) / CLK_NS;
  localparam int WRITE_PULSE_NS = 35;
  localparam int WRITE_CYCLES = (WRITE_PULSE_NS + CLK_NS - 1) / CLK_NS;
  localparam int GAP_NS = 20;
  localparam int GAP_CYCLES = (GAP_NS + CLK_NS - 1) / CLK_NS;
  localparam int TIMER_W = 8;

  typedef enum logic [2:0] {
    OP_ID_READ,
    OP_RESET,
    OP_SECRET_WRITE,
    OP_SECRET_READ,
    OP_BUF_PROGRAM,
    OP_SECTOR_LOCK
  } op_t;

  typedef struct packed {
    op_t op;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
    logic [3:0] index;
    logic [7:0] count;
  } request_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
    logic write;
  } bus_cycle_t;

endpackage : flash_host_pkg

// [testbench/flash_host_ctrl_assertions.sv]
`timescale 1ns/100ps
`default_nettype none
module flash_host_ctrl_assertions
  import flash_host_pkg::*;
(
  // clock and reset
  input wire logic i_clk,
  input wire logic i_reset_n,
  // user side
  input wire logic i_req_valid,
  input wire flash_host_pkg::request_t i_req,
  input wire logic o_req_ready,
  // flash pins
  input wire logic [ADDR_W-1:0] o_addr,
  input wire logic o_ce_n,
  input wire logic o_oe_n,
  input wire logic o_we_n,
  input wire logic [DATA_W-1:0] o_dq,
  input wire logic o_dq_oe
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);
  AST_IDLE_QUIET: assert property (o_req_ready |-> o_ce_n && o_oe_n && o_we_n)
    else $error("strobe while idle");
  AST_NO_CONTENTION: assert property (!o_oe_n |-> !o_dq_oe && o_we_n && !o_ce_n)
    else $error("read with host driving");
  AST_WRITE_DRIVES: assert property (!o_we_n |-> o_dq_oe && !o_ce_n)
    else $error("write without drive");
  AST_WRITE_PULSE: assert property ($fell(o_we_n) |-> !o_we_n[*5] ##1 o_we_n)
    else $error("write pulse length");
  AST_WRITE_HOLD: assert property (!o_we_n |=> o_we_n || ($stable(o_addr) && $stable(o_dq)))
    else $error("write cycle not held");
  AST_READ_PULSE: assert property ($fell(o_oe_n) |-> !o_oe_n[*8] ##1 !o_oe_n)
    else $error("read shorter than access delay");
  AST_FRESH_CE: assert property ($fell(o_oe_n) |-> $fell(o_ce_n))
    else $error("read without new chip enable");
  AST_UNLOCK_PAIR: assert property ($fell(o_we_n) && o_dq[7:0] == UNLOCK_DATA_A
    |-> ##[5:40] ($fell(o_we_n) && o_addr[11:0] == UNLOCK_ADDR_B && o_dq[7:0] == UNLOCK_DATA_B))
    else $error("unlock second cycle missing");
  AST_RESET_CMD: assert property (o_req_ready && i_req_valid && i_req.op == OP_RESET
    |-> ##[26:28] (!o_we_n && o_dq[7:0] == CMD_RESET && o_addr[11:0] == UNLOCK_ADDR_A))
    else $error("reset write missing");
endmodule : flash_host_ctrl_assertions
`default_nettype wire

// [testbench/flash_dev_model.sv]
`timescale 1ns/100ps
`default_nettype none
module flash_dev_model
  import flash_host_pkg::*;
#(
  parameter logic [15:0] MAKER = 16'hA5C3, // arbitrary value
  parameter logic [15:0] PART = 16'h3C5A, // arbitrary value
  parameter logic [2:0] LOCKS = 3'b101,
  parameter logic [3:0] FEAT = 4'h7,
  parameter int RD_DELAY_NS = 60
) (
  // bus
  input wire logic [ADDR_W-1:0] i_addr,
  input wire logic i_ce_n,
  input wire logic i_oe_n,
  input wire logic i_we_n,
  input wire logic [DATA_W-1:0] i_dq,
  output logic [DATA_W-1:0] o_dq,
  // protocol watch
  output logic o_proto_err
);
  typedef enum logic [2:0] {M_READ, M_ID, M_SECRET, M_VOL, M_BUF} mode_t;
  mode_t mode = M_READ;
  logic [1:0] ul = 2'h0, pg = 2'h0;
  logic [9:0] id_sec = 10'h0;
  logic [15:0] pw [4];
  logic [1023:0] prot = '0;
  logic [15:0] rd, last = 16'h0;
  logic ready = 1'b0;
  wire [10:0] a = i_addr[10:0];
  wire [7:0] d = i_dq[7:0];
  wire [9:0] sec = i_addr[25:16];
  // a write lands when the first of its two strobes rises; one combined
  // strobe keeps the simultaneous rise of both from racing
  wire wr_strobe_n = i_we_n | i_ce_n;
  initial o_proto_err = 1'b0;
  always begin
    @(negedge wr_strobe_n);
    @(posedge wr_strobe_n);
    if (mode == M_BUF) begin
      pg <= (pg == 2'h2) ? 2'h0 : pg + 2'h1;
      if (pg == 2'h0 && i_dq !== 16'h0000) o_proto_err <= 1'b1;
      if (pg == 2'h2) mode <= M_READ;
    end else if (pg == 2'h1) begin
      pg <= 2'h0;
      if (mode == M_SECRET) pw[i_addr[1:0]] <= i_dq;
      else prot[sec] <= ~i_dq[0];
    end else if (mode != M_READ) begin
      if (d == CMD_RESET) mode <= M_READ;
      else if (pg == 2'h2 && d == CMD_EXIT_B) begin
        mode <= M_READ;
        pg <= 2'h0;
      end else if (d == CMD_PROGRAM) pg <= 2'h1;
      else if (d == CMD_EXIT_A) pg <= 2'h2;
      else if (d == UNLOCK_DATA_A) o_proto_err <= 1'b1;
    end else if (ul == 2'h2) begin
      ul <= 2'h0;
      id_sec <= sec;
      case (d)
        CMD_ID_ENTRY: mode <= M_ID;
        CMD_SECRET_ENTRY: mode <= M_SECRET;
        CMD_VOLATILE_ENTRY: mode <= M_VOL;
        CMD_BUF_LOAD: mode <= M_BUF;
        default: ; // suspend and resume outside their state are ignored
      endcase
    end else if (ul == 2'h1 && a == UNLOCK_ADDR_B[10:0] && d == UNLOCK_DATA_B) ul <= 2'h2;
    else ul <= {1'b0, a == UNLOCK_ADDR_A[10:0] && d == UNLOCK_DATA_A};
  end
  always_comb begin
    case (mode)
      M_ID: case (i_addr[3:0])
        MAKER_CODE_WORD: rd = MAKER;
        PART_CODE_WORD_A, PART_CODE_WORD_B, PART_CODE_WORD_C: rd = PART;
        SECTOR_PROTECT_STATE: rd = {15'h0, prot[id_sec]};
        LOCK_INDICATOR_WORD: rd = {8'hFF, LOCKS[2:1], 1'b1, LOCKS[0], 4'hF};
        FEATURE_SUPPORT_LOW: rd = {12'h0, FEAT};
        default: rd = 16'h0;
      endcase
      M_SECRET: rd = pw[i_addr[1:0]];
      default: rd = {15'h0, !prot[sec]};
    endcase
  end
  // data only valid after the access delay; a released bus shows the inverse
  always @(i_oe_n, i_ce_n) begin
    ready = 1'b0;
    if (!i_oe_n && !i_ce_n) ready <= #(RD_DELAY_NS) 1'b1; // no page mode at all
  end
  always @(posedge ready) last = rd;
  assign o_dq = ready ? rd : ~last;
endmodule : flash_dev_model
`default_nettype wire

// [testbench/flash_host_ctrl_tb.sv]
`timescale 1ns/100ps
`default_nettype none
module flash_host_ctrl_tb;
  import flash_host_pkg::*;
  localparam logic [15:0] MAKER = 16'hA5C3; // arbitrary value
  localparam logic [15:0] PART = 16'h3C5A; // arbitrary value
  localparam logic [15:0] EXP [6] = '{MAKER, PART, 16'hFFBF, 16'h0007, PART, PART};
  localparam logic [3:0] OFF [6] = '{4'h0, 4'h1, 4'h3, 4'hC, 4'hE, 4'hF};
  logic i_clk = 1'b0, i_reset_n = 1'b0, i_req_valid = 1'b0;
  request_t i_req = '0;
  logic o_req_ready, o_done, o_protected, o_fail, o_ce_n, o_oe_n, o_we_n, o_dq_oe, perr;
  logic [15:0] o_rd_data, o_dq, dev_dq;
  logic [7:0] o_id_valid_mask;
  logic [ADDR_W-1:0] o_addr;
  wire [15:0] dq = o_dq_oe ? o_dq : dev_dq;
  int err_count = 0, checks_done = 0, cyc = 0;
  always #5 i_clk = ~i_clk;
  flash_host_ctrl i_dut (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_req_valid(i_req_valid),
    .i_req(i_req), .o_req_ready(o_req_ready), .o_done(o_done), .o_rd_data(o_rd_data),
    .o_id_valid_mask(o_id_valid_mask), .o_protected(o_protected), .o_fail(o_fail),
    .o_addr(o_addr), .o_ce_n(o_ce_n), .o_oe_n(o_oe_n), .o_we_n(o_we_n), .i_dq(dq),
    .o_dq(o_dq), .o_dq_oe(o_dq_oe));
  flash_dev_model i_dev (.i_addr(o_addr), .i_ce_n(o_ce_n), .i_oe_n(o_oe_n), .i_we_n(o_we_n),
    .i_dq(dq), .o_dq(dev_dq), .o_proto_err(perr));
  //////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic run(input op_t op, input logic [25:0] a, input logic [15:0] d,
                     input logic [3:0] ix);
    int n;
    n = 0;
    while (o_req_ready !== 1'b1) @(negedge i_clk);
    @(posedge i_clk);
    i_req <= '{op: op, addr: a, data: d, index: ix, count: 8'h00};
    i_req_valid <= 1'b1;
    @(posedge i_clk);
    i_req_valid <= 1'b0;
    do begin
      @(negedge i_clk);
      n++;
    end while (o_done !== 1'b1 && n < 600);
    chk({15'h0, o_done}, 16'h1);
  endtask : run
  task automatic t_reset_buf;
    run(OP_RESET, 26'h0, 16'h0, 4'h0);
    chk({15'h0, o_fail}, 16'h0);
    run(OP_BUF_PROGRAM, 26'h0070010, 16'h5A5A, 4'h0);
    chk({15'h0, perr}, 16'h0);
  endtask : t_reset_buf
  task automatic t_id;
    for (int k = 0; k < 6; k++) begin
      run(OP_ID_READ, 26'h0, 16'h0, OFF[k]);
      chk(o_rd_data, EXP[k]);
      chk({15'h0, o_id_valid_mask[0]}, 16'h1);
    end
  endtask : t_id
  task automatic t_prot;
    // lower address bits are off the sector base on purpose
    run(OP_SECTOR_LOCK, 26'h0051234, 16'h0000, 4'h0);
    chk({15'h0, o_protected}, 16'h1);
    run(OP_ID_READ, 26'h0050000, 16'h0, SECTOR_PROTECT_STATE);
    chk(o_rd_data, 16'h0001);
    chk({15'h0, o_protected}, 16'h1);
    run(OP_ID_READ, 26'h0060000, 16'h0, SECTOR_PROTECT_STATE);
    chk(o_rd_data, 16'h0000);
    chk({15'h0, o_protected}, 16'h0);
    run(OP_SECTOR_LOCK, 26'h005FFFF, 16'h0001, 4'h0);
    chk({15'h0, o_protected}, 16'h0);
  endtask : t_prot
  task automatic t_secret;
    for (int k = 0; k < 4; k++) begin
      run(OP_SECRET_WRITE, 26'h0, 16'h1C00 | 16'(k), 4'(k));
      chk({15'h0, o_fail}, 16'h0);
    end
    run(OP_SECRET_WRITE, 26'h0, 16'h1234, 4'h2);
    chk({15'h0, o_fail}, 16'h1);
    for (int k = 3; k >= 0; k--) begin
      run(OP_SECRET_READ, 26'h0, 16'h0, 4'(k));
      chk(o_rd_data, 16'h1C00 | 16'(k));
    end
  endtask : t_secret
  task automatic give_verdict;
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : give_verdict
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20) @(posedge i_clk);
    i_reset_n <= 1'b1;
    t_reset_buf();
    t_id();
    t_prot();
    t_secret();
    chk({15'h0, perr}, 16'h0);
    give_verdict();
  end
  // hang guard, far above the roughly 1500 cycles the run needs
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 30000) begin
      err_count++;
      give_verdict();
    end
  end
endmodule : flash_host_ctrl_tb
bind flash_host_ctrl flash_host_ctrl_assertions i_chk (.i_clk(i_clk), .i_reset_n(i_reset_n),
  .i_req_valid(i_req_valid), .i_req(i_req), .o_req_ready(o_req_ready), .o_addr(o_addr),
  .o_ce_n(o_ce_n), .o_oe_n(o_oe_n), .o_we_n(o_we_n), .o_dq(o_dq), .o_dq_oe(o_dq_oe));
`default_nettype wire
